//--- hw/fsr_pkg.sv
/*
  Shared constants and types for the flow sensor two-wire readout target.
  Assumes a system clock far faster than the serial clock, so that every
  serial clock phase spans many system clock cycles.
*/
`default_nettype none

package fsr_pkg;

  // Bus identity and framing
  localparam logic [6:0] FSR_TGT_ADDR = 7'h28;
  localparam logic FSR_DIR_READ = 1'b1;
  localparam logic FSR_ACK = 1'b0;
  localparam logic [2:0] FSR_LAST_BIT = 3'h7;
  localparam logic [2:0] FSR_FIRST_BYTE = 3'h0;
  localparam logic [2:0] FSR_LAST_BYTE = 3'h4;
  localparam logic [2:0] FSR_CNT_ZERO = 3'h0;

  // Frame byte positions
  localparam logic [2:0] FSR_IDX_CSUM = 3'h0;
  localparam logic [2:0] FSR_IDX_HI = 3'h1;
  localparam logic [2:0] FSR_IDX_LO = 3'h2;
  localparam logic [2:0] FSR_IDX_HI2 = 3'h3;

  // Flow result layout and span
  localparam int FSR_FLOW_W = 12;
  localparam logic [3:0] FSR_HI_PAD = 4'h0;
  localparam logic [7:0] FSR_ZERO_BYTE = 8'h00;
  localparam logic [11:0] FSR_FLOW_MIN = 12'h199;
  localparam logic [11:0] FSR_FLOW_MAX = 12'hE66;
  localparam logic [11:0] FSR_FLOW_RST = FSR_FLOW_MIN;

  // Serial clock rates to be served and the system clock
  localparam int FSR_SCL_STD_KHZ = 100;
  localparam int FSR_SCL_FAST_KHZ = 400;
  localparam int FSR_CLK_MHZ = 200;
  localparam int FSR_CLK_PER_FAST_SCL =
    (FSR_CLK_MHZ * 1000) / FSR_SCL_FAST_KHZ;
  localparam int FSR_SYNC_STAGES = 2;

  // Protocol states
  typedef enum logic [2:0] {
    FSR_IDLE     = 3'b000,
    FSR_ADDR     = 3'b001,
    FSR_ADDR_ACK = 3'b010,
    FSR_RX       = 3'b011,
    FSR_RX_ACK   = 3'b100,
    FSR_TX       = 3'b101,
    FSR_TX_MACK  = 3'b110,
    FSR_WAIT     = 3'b111
  } fsr_state_t;

endpackage

`default_nettype wire

//--- hw/fsr_sync.sv
/*
  Multi-bit two-stage synchroniser for independent single-bit levels.
  Assumes each bit is a level that is read on its own, never as a word.
*/
`timescale 1ns/1ps
`default_nettype none

module fsr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // First stage feeds only the second stage
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  // Reset to released bus levels
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta <= {W{1'b1}};
      q_o <= {W{1'b1}};
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end

endmodule

`default_nettype wire

//--- hw/fsr_bit_capture.sv
/*
  Serial-clock domain data sampler: takes the data line on each rising
  serial clock edge. Assumes the reader qualifies the held bit with its own
  synchronised view of the serial clock, and that the clock may stand still.
*/
`timescale 1ns/1ps
`default_nettype none

module fsr_bit_capture (
  // Link clock
  input wire logic scl_clk_i,
  // Data line
  input wire logic sda_i,
  output logic bit_o
);

  logic next_bit;

  // No reset: the value is only read after a qualified rising edge
  always_comb begin
    next_bit = sda_i;
  end

  // Sample on the rising serial clock edge
  always_ff @(posedge scl_clk_i) begin
    bit_o <= next_bit;
  end

endmodule

`default_nettype wire

//--- hw/fsr_readout.sv
/*
  Read-only two-wire serial target of the air-velocity sensor readout.
  Returns a five-byte frame: checksum, flow high, flow low, two tail bytes.
  Assumes open-drain pads outside (sda_oe_o pulls low), external pull-ups,
  and a flow result presented on the system clock by the sensing logic.
*/
// Contract
// - Target only; serves 100 kHz and 400 kHz serial clock rates.
// - Answer only target address 0x28; silent for every other address.
// - Falling data while clock high starts address reception.
// - Rising data while clock high returns to idle, bus released.
// - Each transfer is eight bits plus one response bit, low means ack.
// - Acknowledge received bytes by pulling data low, then release.
// - Sample on rising clock; change data only while clock is low.
// - Keep latest flow result ready; no trigger command needed.
// - Transmit every byte most significant bit first.
// - Read sends checksum first, then flow high, then flow low.
// - Five-byte frame; tail repeats flow bytes or is two zeros.
// - Flow is 12-bit; high byte's upper nibble carries zeros.
// - Checksum is negated 8-bit sum of following data bytes.
// - Reported count stays within 409 to 3686.
`timescale 1ns/1ps
`default_nettype none

module fsr_readout (
  // System clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Flow result from the sensing logic
  input wire logic [fsr_pkg::FSR_FLOW_W-1:0] flow_count_i,
  input wire logic flow_valid_i,
  // Tail byte selection, zeros when high
  input wire logic tail_zero_i,
  // Status
  output logic busy_o,
  output logic [fsr_pkg::FSR_FLOW_W-1:0] flow_o
);
  import fsr_pkg::*;

  // Synchronised pins, their previous values and bus events
  logic scl_s, sda_s, scl_d, sda_d;
  logic next_scl_d, next_sda_d;
  logic link_bit, rise, fall, start_seen, stop_seen;

  // Protocol state
  fsr_state_t state, next_state;
  logic [2:0] cnt, next_cnt, idx, next_idx;
  logic [6:0] shreg, next_shreg;
  logic oe, next_oe, snap_tz, next_snap_tz;
  logic [7:0] snap_hi, next_snap_hi, snap_lo, next_snap_lo;

  // Measurement holding
  logic [FSR_FLOW_W-1:0] flow;
  logic [FSR_FLOW_W-1:0] next_flow;

  // Frame assembly
  logic [7:0] tail_hi;
  logic [7:0] tail_lo;
  logic [7:0] csum;
  logic [7:0] tx_byte;

  // Clamp into the reported span
  function automatic logic [FSR_FLOW_W-1:0] clamp_flow(
    input logic [FSR_FLOW_W-1:0] raw
  );
    logic [FSR_FLOW_W-1:0] v;
    v = raw;
    if (raw < FSR_FLOW_MIN) begin
      v = FSR_FLOW_MIN;
    end else if (raw > FSR_FLOW_MAX) begin
      v = FSR_FLOW_MAX;
    end
    return v;
  endfunction

  // Pick the byte at one frame position
  function automatic logic [7:0] frame_byte(
    input logic [2:0] pos,
    input logic [7:0] cs,
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic [7:0] thi,
    input logic [7:0] tlo
  );
    logic [7:0] b;
    case (pos)
      FSR_IDX_CSUM: b = cs;
      FSR_IDX_HI: b = hi;
      FSR_IDX_LO: b = lo;
      FSR_IDX_HI2: b = thi;
      default: b = tlo;
    endcase
    return b;
  endfunction

  // Pins cross into the system domain before bus event decoding
  fsr_sync #(
    .W(FSR_SYNC_STAGES)
  ) u_pin_sync (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .d_i({scl_i, sda_i}),
    .q_o({scl_s, sda_s})
  );

  // Data bit sampled in the serial clock domain
  // sample rising edge
  fsr_bit_capture u_capture (
    .scl_clk_i(scl_i),
    .sda_i(sda_i),
    .bit_o(link_bit)
  );

  // Edge history of the synchronised pins
  always_comb begin
    next_scl_d = scl_s;
    next_sda_d = sda_s;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

  // Bus events; link_bit is read only after the synchronised rise,
  // by which time it has settled and holds until the next rise.
  // start detection
  always_comb begin
    rise = scl_s & ~scl_d;
    fall = ~scl_s & scl_d;
    start_seen = scl_s & scl_d & sda_d & ~sda_s;
    stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  end

  // Keep the newest clamped result
  // always ready
  always_comb begin
    next_flow = flow;
    if (flow_valid_i) begin
      next_flow = clamp_flow(flow_count_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flow <= FSR_FLOW_RST;
    end else begin
      flow <= next_flow;
    end
  end

  // Frame bytes from the snapshot
  // tail bytes
  always_comb begin
    tail_hi = snap_tz ? FSR_ZERO_BYTE : snap_hi;
    tail_lo = snap_tz ? FSR_ZERO_BYTE : snap_lo;
    csum = 8'(-(8'(snap_hi + snap_lo + tail_hi + tail_lo)));
    tx_byte = frame_byte(idx, csum, snap_hi, snap_lo, tail_hi, tail_lo);
  end

  // Protocol next state; start and stop take priority over bit events
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    next_shreg = shreg;
    next_oe = oe;
    next_snap_hi = snap_hi;
    next_snap_lo = snap_lo;
    next_snap_tz = snap_tz;
    if (start_seen) begin
      next_state = FSR_ADDR;
      next_cnt = FSR_CNT_ZERO;
      next_idx = FSR_FIRST_BYTE;
      next_oe = 1'b0;
      next_snap_hi = {FSR_HI_PAD, flow[11:8]};
      next_snap_lo = flow[7:0];
      next_snap_tz = tail_zero_i;
    end else if (stop_seen) begin
      next_state = FSR_IDLE;
      next_oe = 1'b0;
    end else begin
      case (state)
        FSR_IDLE: begin
          next_oe = 1'b0;
        end
        FSR_ADDR: begin
          if (rise) begin
            next_shreg = {shreg[5:0], link_bit};
            next_cnt = cnt + 3'h1;
            if (cnt == FSR_LAST_BIT) begin
              next_cnt = FSR_CNT_ZERO;
              if (shreg == FSR_TGT_ADDR) begin
                next_state = FSR_ADDR_ACK;
                next_shreg = {6'h00, link_bit};
              end else begin
                next_state = FSR_WAIT;
              end
            end
          end
        end
        FSR_ADDR_ACK, FSR_RX_ACK: begin
          if (fall) begin
            next_oe = 1'b1;
          end
          if (rise) begin
            if (state == FSR_ADDR_ACK && shreg[0] == FSR_DIR_READ) begin
              next_state = FSR_TX;
            end else begin
              next_state = FSR_RX;
            end
          end
        end
        FSR_RX: begin
          if (fall) begin
            next_oe = 1'b0;
          end
          if (rise) begin
            next_cnt = cnt + 3'h1;
            if (cnt == FSR_LAST_BIT) begin
              next_cnt = FSR_CNT_ZERO;
              next_state = FSR_RX_ACK;
            end
          end
        end
        FSR_TX: begin
          if (fall) begin
            next_oe = ~tx_byte[3'(FSR_LAST_BIT - cnt)];
          end
          if (rise) begin
            next_cnt = cnt + 3'h1;
            if (cnt == FSR_LAST_BIT) begin
              next_cnt = FSR_CNT_ZERO;
              next_state = FSR_TX_MACK;
            end
          end
        end
        FSR_TX_MACK: begin
          if (fall) begin
            next_oe = 1'b0;
          end
          if (rise) begin
            if (link_bit == FSR_ACK) begin
              next_state = FSR_TX;
              if (idx == FSR_LAST_BYTE) begin
                next_idx = FSR_FIRST_BYTE;
              end else begin
                next_idx = idx + 3'h1;
              end
            end else begin
              next_state = FSR_WAIT;
            end
          end
        end
        FSR_WAIT: begin
          next_oe = 1'b0;
        end
        default: begin
          next_state = FSR_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // Protocol registers
  // target role only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= FSR_IDLE;
      cnt <= FSR_CNT_ZERO;
      idx <= FSR_FIRST_BYTE;
      shreg <= 7'h00;
      oe <= 1'b0;
      snap_hi <= {FSR_HI_PAD, FSR_FLOW_RST[11:8]};
      snap_lo <= FSR_FLOW_RST[7:0];
      snap_tz <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      shreg <= next_shreg;
      oe <= next_oe;
      snap_hi <= next_snap_hi;
      snap_lo <= next_snap_lo;
      snap_tz <= next_snap_tz;
    end
  end

  // Outputs; the pad only ever pulls low
  always_comb begin
    sda_o = 1'b0;
    sda_oe_o = oe;
    busy_o = (state != FSR_IDLE);
    flow_o = flow;
  end

endmodule

`default_nettype wire

//--- dv/fsr_readout_chk.sv
/*
  Checker for the flow sensor readout target, watching top ports only.
  Assumes serial clock phases of many system clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_readout_chk
  import fsr_pkg::*;
(
  // Clock, reset and pins
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Flow path and status
  input wire logic [FSR_FLOW_W-1:0] flow_count_i,
  input wire logic flow_valid_i,
  input wire logic tail_zero_i,
  input wire logic busy_o,
  input wire logic [FSR_FLOW_W-1:0] flow_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  chk_sda_only_low: assert property (sda_o == 1'b0)
    else $error("data driven high");
  chk_flow_take: assert property (flow_valid_i && flow_count_i >= FSR_FLOW_MIN
    && flow_count_i <= FSR_FLOW_MAX |=> flow_o == $past(flow_count_i))
    else $error("flow not taken");
  chk_flow_clamp: assert property (flow_valid_i && flow_count_i < FSR_FLOW_MIN
    |=> flow_o == FSR_FLOW_MIN)
    else $error("flow not clamped");
  chk_clamp_high: assert property (flow_valid_i && flow_count_i > FSR_FLOW_MAX
    |=> flow_o == FSR_FLOW_MAX)
    else $error("flow not clamped high");
  chk_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved with clock high");
  chk_oe_held_high: assert property (scl_i && $past(scl_i, 4)
    |-> $stable(sda_oe_o))
    else $error("data unstable in high phase");
  chk_idle_quiet: assert property (!busy_o |-> !sda_oe_o)
    else $error("driving while idle");
  chk_start_busy: assert property ($fell(sda_i) && scl_i && !busy_o
    |-> ##[1:6] busy_o)
    else $error("start missed");
  chk_stop_idle: assert property ($rose(sda_i) && scl_i
    |-> ##[1:6] !busy_o)
    else $error("stop missed");
endmodule
bind fsr_readout fsr_readout_chk u_chk (.clock_i(clock_i), .reset_i(reset_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .flow_count_i(flow_count_i), .flow_valid_i(flow_valid_i),
  .tail_zero_i(tail_zero_i), .busy_o(busy_o), .flow_o(flow_o));
`default_nettype wire

//--- dv/fsr_master_model.sv
/*
  Two-wire bus controller model: makes the serial clock, pulls data low.
  Assumes the bench resolves the pulled-up data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_master_model (
  // Bus lines
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  localparam int H = 80;
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // move data in low phase, sample after rise
  task automatic bit_x(input logic b, output logic r);
    #20 pull_o = !b;
    #(H-20) scl_o = 1'b1;
    #1 r = sda_i;
    #(H-1) scl_o = 1'b0;
  endtask
  // data falls while clock high; from a low clock this is a restart
  task automatic start();
    if (!scl_o) begin
      #20 pull_o = 1'b0;
      #(H-20) scl_o = 1'b1;
      #H;
    end
    pull_o = 1'b1;
    #H scl_o = 1'b0;
  endtask
  task automatic stop();
    #20 pull_o = 1'b1;
    #(H-20) scl_o = 1'b1;
    #H pull_o = 1'b0;
    #H;
  endtask
  // eight bits then response read back
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic recv(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      v[i] = r;
    end
    bit_x(ack, r);
  endtask
endmodule
`default_nettype wire

//--- dv/fsr_readout_bench.sv
/*
  Self-checking bench of the flow sensor readout target.
  Assumes the bound checker and the bus controller model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_readout_bench;
  import fsr_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] flow_count_i = 12'h000;
  logic flow_valid_i = 1'b0;
  logic tail_zero_i = 1'b0;
  logic sda_o, sda_oe_o, busy_o, scl, pull, a;
  logic [11:0] flow_o;
  logic [7:0] b;
  int err_count = 0;
  int n_checks = 0;
  int v;
  // Pull-up wins unless someone pulls low
  wire logic sda = !(sda_oe_o || pull);
  always #2.5 clock_i = !clock_i;
  fsr_readout DUT (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .flow_count_i(flow_count_i), .flow_valid_i(flow_valid_i),
    .tail_zero_i(tail_zero_i), .busy_o(busy_o), .flow_o(flow_o));
  fsr_master_model M (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input int e, input logic [11:0] g);
    n_checks++;
    if (g !== e[11:0]) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  function automatic int clamp(input int x);
    return x < 409 ? 409 : (x > 3686 ? 3686 : x);
  endfunction
  // One-cycle strobe, result due next cycle
  task automatic set_flow(input int x, input logic tz);
    @(posedge clock_i);
    #1 flow_count_i = x[11:0];
    flow_valid_i = 1'b1;
    tail_zero_i = tz;
    @(posedge clock_i);
    #1 flow_valid_i = 1'b0;
    chk("flow_o", clamp(x), flow_o);
  endtask
  // Bounded wait for the end of a transaction
  task automatic wait_idle();
    for (int k = 0; k < 40 && busy_o !== 1'b0; k++) begin
      @(posedge clock_i);
      #1;
    end
    chk("busy_o", 0, busy_o);
    if (busy_o !== 1'b0) test_done();
  endtask
  // Full frame plus one wrapped byte, flow moved mid-frame
  task automatic read_frame(input int f, input logic tz);
    int q[$];
    int s;
    q = {f >> 8, f & 255, tz ? 0 : f >> 8, tz ? 0 : f & 255};
    s = q.sum();
    q.push_front((256 - s % 256) % 256);
    s = 0;
    M.start();
    M.send(8'h51, a);
    chk("addr ack", 0, a);
    chk("busy_o frame", 1, busy_o);
    set_flow($urandom_range(4095), !tz);
    for (int i = 0; i < 6; i++) begin
      M.recv(i == 5, b);
      chk("frame byte", q[i % 5], b);
      if (i < 5) s += b;
    end
    chk("frame sum", 0, s % 256);
    M.stop();
    wait_idle();
  endtask
  // Watchdog
  initial begin
    #400000;
    err_count++;
    test_done();
  end
  initial begin
    void'($urandom(93));
    repeat (12) @(posedge clock_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    chk("flow_o rst", 409, flow_o);
    chk("oe rst", 0, sda_oe_o);
    for (int n = 0; n < 4; n++) begin
      v = n == 0 ? 0 : (n == 1 ? 4095 : $urandom_range(4095));
      set_flow(v, n[0]);
      // Foreign address left open, the frame then follows a restart
      if (n == 2) begin
        M.start();
        M.send(8'h53, a);
        chk("rs foreign ack", 1, a);
        M.recv(1'b1, b);
        chk("rs foreign data", 255, b);
      end
      read_frame(clamp(v), n[0]);
    end
    // Foreign address: no ack, line left released
    M.start();
    M.send(8'h53, a);
    chk("foreign ack", 1, a);
    M.recv(1'b1, b);
    chk("foreign data", 255, b);
    M.stop();
    wait_idle();
    // Write to own address: every byte acknowledged
    M.start();
    M.send(8'h50, a);
    chk("write addr ack", 0, a);
    M.send($urandom_range(255), a);
    chk("write data ack", 0, a);
    M.stop();
    wait_idle();
    test_done();
  end
endmodule
`default_nettype wire
